// ==== core/udc_pkg.sv ====
package udc_pkg;
   // Clock and fast counter limits
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned FC_MAX_RATE_HZ = 100_000;
   localparam int unsigned FC_MIN_EVT_CYC = CLK_HZ / FC_MAX_RATE_HZ;
   localparam int unsigned CNT_W_DEF = 16;
   localparam int unsigned ADDR_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_PC_CTRL = 8'h00;
   localparam logic [7:0] OFS_PRESET = 8'h04;
   localparam logic [7:0] OFS_UP_CV = 8'h08;
   localparam logic [7:0] OFS_DN_CV = 8'h0c;
   localparam logic [7:0] OFS_UD_CV = 8'h10;
   localparam logic [7:0] OFS_PC_STAT = 8'h14;
   localparam logic [7:0] OFS_FC_CFG = 8'h18;
   localparam logic [7:0] OFS_FC_NEW_DIR = 8'h1c;
   localparam logic [7:0] OFS_FC_NEW_COUNT = 8'h20;
   localparam logic [7:0] OFS_FC_NEW_REFERENCE = 8'h24;
   localparam logic [7:0] OFS_FC_NEW_PER = 8'h28;
   localparam logic [7:0] OFS_FC_CMD = 8'h2c;
   localparam logic [7:0] OFS_FC_COUNT = 8'h30;
   localparam logic [7:0] OFS_FC_REF = 8'h34;
   localparam logic [7:0] OFS_FC_STATE = 8'h38;

   // Program counter control bits, one evaluation per write
   localparam int unsigned PC_IN_W = 8;
   localparam int unsigned B_UP_CU = 0;
   localparam int unsigned B_UP_RST = 1;
   localparam int unsigned B_DN_CD = 2;
   localparam int unsigned B_DN_LOAD = 3;
   localparam int unsigned B_UD_CU = 4;
   localparam int unsigned B_UD_CD = 5;
   localparam int unsigned B_UD_RST = 6;
   localparam int unsigned B_UD_LOAD = 7;
   localparam int unsigned B_SIGNED = 8;

   // Fast counter configuration and command bits
   localparam int unsigned B_CFG_DIR_PROG = 0;
   localparam int unsigned B_CFG_FREQ = 1;
   localparam int unsigned B_CMD_DIR = 0;
   localparam int unsigned B_CMD_CV = 1;
   localparam int unsigned B_CMD_RV = 2;
   localparam int unsigned B_CMD_PER = 3;
   localparam int unsigned CMD_ID_LO = 8;
   localparam int unsigned CMD_ID_HI = 15;
   localparam int unsigned B_ST_ENO = 16;
   localparam int unsigned B_ST_BUSY = 17;

   // Status codes
   localparam logic [15:0] ST_OK = 16'h0000;
   localparam logic [15:0] ST_BAD_ID = 16'h80a1;
   localparam logic [15:0] ST_BAD_DIR = 16'h80b1;
   localparam logic [15:0] ST_BAD_CV = 16'h80b2;
   localparam logic [15:0] ST_BAD_RV = 16'h80b3;
   localparam logic [15:0] ST_BAD_PER = 16'h80b4;

   // Direction and measurement period codes (period in milliseconds)
   localparam logic [15:0] DIR_FWD = 16'h0001;
   localparam logic [15:0] DIR_BWD = 16'hffff;
   localparam logic [15:0] PER_10MS = 16'h000a;
   localparam logic [15:0] PER_100MS = 16'h0064;
   localparam logic [15:0] PER_1S = 16'h03e8;
   localparam logic [7:0] FC_ID_DEF = 8'h01;
endpackage : udc_pkg

// ==== core/udc_top.sv ====
// Functional notes
// - Up counter adds one on each rising edge of its count-up input.
// - Up counter output high while count is at or above preset.
// - Reset rising edge zeroes up and up/down counts.
// - Down counter subtracts one on each rising edge of count-down input.
// - Down counter output high while count is zero or negative.
// - Load rising edge copies preset into down and up/down counts.
// - Up/down counter increments on up edges, decrements on down edges.
// - Up/down upper-limit output high while count at or above preset.
// - Up/down lower-limit output high while count at or below zero.
// - Counts saturate at type limits given width and signedness.
// - Fast counter counts pin events independent of scans, up to 100 kHz.
// - Each set request flag loads its paired new value into fast counter.
// - All flagged updates apply within one command execution.
// - New direction is 1 forward or -1 backward.
// - Period update only in frequency mode, one of three periods.
// - Values of unflagged parameters are ignored.
// - Direction request acts only when direction is under program control.
// - Busy output always reads zero.
// - On error enable-out clears and a status code is reported; zero is success.
// - Unknown counter identifier reports its own status code.
// - Bad direction, count, reference, period report distinct codes in order.
// - Fast counter keeps counting while read; read gives live count.
// - Fast counter raises an event when its count changes to equal the reference.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module udc_top #(
   parameter int unsigned CNT_W = udc_pkg::CNT_W_DEF,
   parameter logic [7:0] FC_ID = udc_pkg::FC_ID_DEF  // Arbitrary identifier value
) (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_NRST,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [udc_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // Fast counter pins
   input wire logic I_FAST_EVT,
   input wire logic I_FAST_DIR,
   // Counter outputs
   output logic O_UP_Q,
   output logic O_DN_Q,
   output logic O_UD_QU,
   output logic O_UD_QD,
   output logic O_FAST_MATCH,
   output logic O_FAST_BUSY,
   output logic O_ENABLE_OUT
);
   localparam logic [CNT_W-1:0] ZERO = '0;

   function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v, input logic sgn);
      logic [CNT_W-1:0] lim;
      lim = sgn ? {1'b0, {(CNT_W-1){1'b1}}} : {CNT_W{1'b1}};
      return (v == lim) ? v : v + 1'b1;
   endfunction : inc_sat

   function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v, input logic sgn);
      logic [CNT_W-1:0] lim;
      lim = sgn ? {1'b1, {(CNT_W-1){1'b0}}} : ZERO;
      return (v == lim) ? v : v - 1'b1;
   endfunction : dec_sat

   function automatic logic ge_f(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b,
                                 input logic sgn);
      return sgn ? ($signed(a) >= $signed(b)) : (a >= b);
   endfunction : ge_f

   function automatic logic le0_f(input logic [CNT_W-1:0] a, input logic sgn);
      return (a == ZERO) || (sgn && a[CNT_W-1]);
   endfunction : le0_f

   // APB decode
   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   wire setup = I_PSEL && !I_PENABLE;
   wire wr_en = I_PSEL && I_PENABLE && pready_reg && I_PWRITE;
   wire [7:0] addr = I_PADDR;
   wire a_ctrl = addr == udc_pkg::OFS_PC_CTRL;
   wire a_pre = addr == udc_pkg::OFS_PRESET;
   wire a_cfg = addr == udc_pkg::OFS_FC_CFG;
   wire a_ndir = addr == udc_pkg::OFS_FC_NEW_DIR;
   wire a_ncv = addr == udc_pkg::OFS_FC_NEW_COUNT;
   wire a_nrv = addr == udc_pkg::OFS_FC_NEW_REFERENCE;
   wire a_nper = addr == udc_pkg::OFS_FC_NEW_PER;
   wire a_cmd = addr == udc_pkg::OFS_FC_CMD;

   // Program counter state
   logic [udc_pkg::PC_IN_W-1:0] prev_reg;
   logic signed_reg;
   logic [CNT_W-1:0] preset_reg;
   logic [CNT_W-1:0] up_cv_reg, up_cv_next;
   logic [CNT_W-1:0] dn_cv_reg, dn_cv_next;
   logic [CNT_W-1:0] ud_cv_reg, ud_cv_next;
   logic up_q_reg, dn_q_reg, ud_qu_reg, ud_qd_reg;

   wire eval = wr_en && a_ctrl;
   wire [udc_pkg::PC_IN_W-1:0] lvl = I_PWDATA[udc_pkg::PC_IN_W-1:0];
   wire [udc_pkg::PC_IN_W-1:0] rise = lvl & ~prev_reg;
   wire sgn_now = eval ? I_PWDATA[udc_pkg::B_SIGNED] : signed_reg;
   wire up_cu_r = eval && rise[udc_pkg::B_UP_CU];
   wire up_rst_r = eval && rise[udc_pkg::B_UP_RST];
   wire dn_cd_r = eval && rise[udc_pkg::B_DN_CD];
   wire dn_ld_r = eval && rise[udc_pkg::B_DN_LOAD];
   wire ud_cu_r = eval && rise[udc_pkg::B_UD_CU];
   wire ud_cd_r = eval && rise[udc_pkg::B_UD_CD];
   wire ud_rst_r = eval && rise[udc_pkg::B_UD_RST];
   wire ud_ld_r = eval && rise[udc_pkg::B_UD_LOAD];

   // Reset wins over count; load wins over count; up and down together cancel
   assign up_cv_next = up_rst_r ? ZERO :
                       up_cu_r ? inc_sat(up_cv_reg, sgn_now) : up_cv_reg;
   assign dn_cv_next = dn_ld_r ? preset_reg :
                       dn_cd_r ? dec_sat(dn_cv_reg, sgn_now) : dn_cv_reg;
   assign ud_cv_next = ud_rst_r ? ZERO :
                       ud_ld_r ? preset_reg :
                       (ud_cu_r && !ud_cd_r) ? inc_sat(ud_cv_reg, sgn_now) :
                       (ud_cd_r && !ud_cu_r) ? dec_sat(ud_cv_reg, sgn_now) : ud_cv_reg;

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         prev_reg <= '0;
         signed_reg <= 1'b0;
         preset_reg <= '0;
         up_cv_reg <= '0;
         dn_cv_reg <= '0;
         ud_cv_reg <= '0;
      end else begin
         if (eval) begin
            prev_reg <= lvl;
            signed_reg <= I_PWDATA[udc_pkg::B_SIGNED];
         end
         if (wr_en && a_pre) begin
            preset_reg <= I_PWDATA[CNT_W-1:0];
         end
         up_cv_reg <= up_cv_next;
         dn_cv_reg <= dn_cv_next;
         ud_cv_reg <= ud_cv_next;
      end
   end

   // Limit outputs follow the stored counts one clock later
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         up_q_reg <= 1'b1;
         dn_q_reg <= 1'b1;
         ud_qu_reg <= 1'b1;
         ud_qd_reg <= 1'b1;
      end else begin
         up_q_reg <= ge_f(up_cv_reg, preset_reg, signed_reg);
         dn_q_reg <= le0_f(dn_cv_reg, signed_reg);
         ud_qu_reg <= ge_f(ud_cv_reg, preset_reg, signed_reg);
         ud_qd_reg <= le0_f(ud_cv_reg, signed_reg);
      end
   end

   // Fast counter pin synchronisers; level accepted once stages two and three agree
   logic [2:0] evt_sync_reg, dir_sync_reg;
   logic evt_lvl_reg, dir_lvl_reg;
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         evt_sync_reg <= '0;
         dir_sync_reg <= '0;
         evt_lvl_reg <= 1'b0;
         dir_lvl_reg <= 1'b0;
      end else begin
         evt_sync_reg <= {evt_sync_reg[1:0], I_FAST_EVT};
         dir_sync_reg <= {dir_sync_reg[1:0], I_FAST_DIR};
         if (evt_sync_reg[1] == evt_sync_reg[2]) begin
            evt_lvl_reg <= evt_sync_reg[2];
         end
         if (dir_sync_reg[1] == dir_sync_reg[2]) begin
            dir_lvl_reg <= dir_sync_reg[2];
         end
      end
   end
   wire evt_step = evt_sync_reg[1] && evt_sync_reg[2] && !evt_lvl_reg;

   // Fast counter control state
   logic dir_prog_reg, freq_mode_reg, prog_fwd_reg;
   logic [15:0] new_dir_reg, new_per_reg, period_reg, status_reg;
   logic [31:0] new_count_reg, new_reference_reg, fc_cnt_reg, fc_ref_reg;
   logic eno_reg, match_reg, busy_reg;

   wire cmd = wr_en && a_cmd;
   wire f_dir = I_PWDATA[udc_pkg::B_CMD_DIR];
   wire f_cv = I_PWDATA[udc_pkg::B_CMD_CV];
   wire f_rv = I_PWDATA[udc_pkg::B_CMD_RV];
   wire f_per = I_PWDATA[udc_pkg::B_CMD_PER];
   wire id_ok = I_PWDATA[udc_pkg::CMD_ID_HI:udc_pkg::CMD_ID_LO] == FC_ID;
   // Only flagged values are checked, so stale unflagged values never cause errors
   wire dir_bad = f_dir && (new_dir_reg != udc_pkg::DIR_FWD)
                  && (new_dir_reg != udc_pkg::DIR_BWD);
   wire cv_bad = f_cv && freq_mode_reg;
   wire rv_bad = f_rv && freq_mode_reg;
   wire per_bad = f_per && (!freq_mode_reg || ((new_per_reg != udc_pkg::PER_10MS)
                  && (new_per_reg != udc_pkg::PER_100MS)
                  && (new_per_reg != udc_pkg::PER_1S)));
   wire [15:0] cmd_status = !id_ok ? udc_pkg::ST_BAD_ID :
                            dir_bad ? udc_pkg::ST_BAD_DIR :
                            cv_bad ? udc_pkg::ST_BAD_CV :
                            rv_bad ? udc_pkg::ST_BAD_RV :
                            per_bad ? udc_pkg::ST_BAD_PER : udc_pkg::ST_OK;
   wire cmd_ok = cmd && (cmd_status == udc_pkg::ST_OK);
   wire fwd_now = dir_prog_reg ? prog_fwd_reg : !dir_lvl_reg;
   wire [31:0] fc_cnt_next = (cmd_ok && f_cv) ? new_count_reg :
                             evt_step ? (fwd_now ? fc_cnt_reg + 32'h1 : fc_cnt_reg - 32'h1) :
                             fc_cnt_reg;
   wire [31:0] fc_ref_next = (cmd_ok && f_rv) ? new_reference_reg : fc_ref_reg;

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         dir_prog_reg <= 1'b0;
         freq_mode_reg <= 1'b0;
         new_dir_reg <= udc_pkg::DIR_FWD;
         new_count_reg <= '0;
         new_reference_reg <= '0;
         new_per_reg <= udc_pkg::PER_1S;
      end else begin
         if (wr_en && a_cfg) begin
            dir_prog_reg <= I_PWDATA[udc_pkg::B_CFG_DIR_PROG];
            freq_mode_reg <= I_PWDATA[udc_pkg::B_CFG_FREQ];
         end
         if (wr_en && a_ndir) begin
            new_dir_reg <= I_PWDATA[15:0];
         end
         if (wr_en && a_ncv) begin
            new_count_reg <= I_PWDATA;
         end
         if (wr_en && a_nrv) begin
            new_reference_reg <= I_PWDATA;
         end
         if (wr_en && a_nper) begin
            new_per_reg <= I_PWDATA[15:0];
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         prog_fwd_reg <= 1'b1;
         period_reg <= udc_pkg::PER_1S;
         fc_cnt_reg <= '0;
         fc_ref_reg <= '0;
         status_reg <= udc_pkg::ST_OK;
         eno_reg <= 1'b1;
         match_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         if (cmd_ok && f_dir && dir_prog_reg) begin
            prog_fwd_reg <= new_dir_reg == udc_pkg::DIR_FWD;
         end
         if (cmd_ok && f_per) begin
            period_reg <= new_per_reg;
         end
         if (cmd) begin
            status_reg <= cmd_status;
            eno_reg <= cmd_ok;
         end
         fc_cnt_reg <= fc_cnt_next;
         fc_ref_reg <= fc_ref_next;
         match_reg <= (fc_cnt_next != fc_cnt_reg) && (fc_cnt_next == fc_ref_next);
         // Commands finish in one clock, so there is never a busy phase to report
         busy_reg <= 1'b0;
      end
   end

   // Read mux; unmapped addresses answer with an error and zero data
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      if (a_ctrl) begin
         rd_mux = {23'h0, signed_reg, prev_reg};
      end else if (a_pre) begin
         rd_mux[CNT_W-1:0] = preset_reg;
      end else if (addr == udc_pkg::OFS_UP_CV) begin
         rd_mux[CNT_W-1:0] = up_cv_reg;
      end else if (addr == udc_pkg::OFS_DN_CV) begin
         rd_mux[CNT_W-1:0] = dn_cv_reg;
      end else if (addr == udc_pkg::OFS_UD_CV) begin
         rd_mux[CNT_W-1:0] = ud_cv_reg;
      end else if (addr == udc_pkg::OFS_PC_STAT) begin
         rd_mux[3:0] = {ud_qd_reg, ud_qu_reg, dn_q_reg, up_q_reg};
      end else if (a_cfg) begin
         rd_mux[1:0] = {freq_mode_reg, dir_prog_reg};
      end else if (a_ndir) begin
         rd_mux[15:0] = new_dir_reg;
      end else if (a_ncv) begin
         rd_mux = new_count_reg;
      end else if (a_nrv) begin
         rd_mux = new_reference_reg;
      end else if (a_nper) begin
         rd_mux[15:0] = new_per_reg;
      end else if (a_cmd) begin
         rd_mux[15:0] = status_reg;
         rd_mux[udc_pkg::B_ST_ENO] = eno_reg;
         rd_mux[udc_pkg::B_ST_BUSY] = 1'b0;
      end else if (addr == udc_pkg::OFS_FC_COUNT) begin
         rd_mux = fc_cnt_reg;
      end else if (addr == udc_pkg::OFS_FC_REF) begin
         rd_mux = fc_ref_reg;
      end else if (addr == udc_pkg::OFS_FC_STATE) begin
         rd_mux = {period_reg, 15'h0, fwd_now};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // One access cycle: data and ready are set up during the setup phase
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pready_reg <= 1'b0;
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         prdata_reg <= (setup && !I_PWRITE) ? rd_mux : 32'h0;
         pslverr_reg <= setup && !rd_hit;
      end
   end

   assign O_PREADY = pready_reg;
   assign O_PRDATA = prdata_reg;
   assign O_PSLVERR = pslverr_reg;
   assign O_UP_Q = up_q_reg;
   assign O_DN_Q = dn_q_reg;
   assign O_UD_QU = ud_qu_reg;
   assign O_UD_QD = ud_qd_reg;
   assign O_FAST_MATCH = match_reg;
   assign O_FAST_BUSY = busy_reg;
   assign O_ENABLE_OUT = eno_reg;

   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_NRST);

   up_step_a: assert property (up_cu_r && !up_rst_r && !signed_reg && !sgn_now
      && up_cv_reg != {CNT_W{1'b1}} |=> up_cv_reg == $past(up_cv_reg) + 1'b1)
      else $error("up count did not step");
   up_q_a: assert property (O_UP_Q == $past(ge_f(up_cv_reg, preset_reg, signed_reg)))
      else $error("up output wrong");
   rst_zero_a: assert property (up_rst_r && ud_rst_r |=> up_cv_reg == ZERO && ud_cv_reg == ZERO)
      else $error("reset edge did not zero counts");
   dn_step_a: assert property (dn_cd_r && !dn_ld_r && dn_cv_reg != ZERO && !sgn_now
      |=> dn_cv_reg == $past(dn_cv_reg) - 1'b1)
      else $error("down count did not step");
   load_pv_a: assert property (dn_ld_r |=> dn_cv_reg == $past(preset_reg))
      else $error("load did not copy preset");
   ud_low_a: assert property (O_UD_QD == $past(le0_f(ud_cv_reg, signed_reg)))
      else $error("lower limit missing");
   sat_low_a: assert property (dn_cd_r && !dn_ld_r && dn_cv_reg == ZERO && !sgn_now
      |=> dn_cv_reg == ZERO)
      else $error("unsigned down count wrapped");
   bad_id_a: assert property (cmd && !id_ok |=> status_reg == udc_pkg::ST_BAD_ID
      && !O_ENABLE_OUT && fc_ref_reg == $past(fc_ref_reg))
      else $error("bad id not reported");
   cv_load_a: assert property (cmd_ok && f_cv |=> fc_cnt_reg == $past(new_count_reg))
      else $error("new count not loaded");
   dir_hw_a: assert property (cmd && !dir_prog_reg |=> prog_fwd_reg == $past(prog_fwd_reg))
      else $error("direction changed under hardware control");
   busy_zero_a: assert property (!O_FAST_BUSY)
      else $error("busy set");
   evt_cnt_a: assert property (evt_step && !cmd |=> fc_cnt_reg != $past(fc_cnt_reg))
      else $error("fast event lost");

   multi_cmd_c: cover property (cmd_ok && f_cv && f_rv && f_per);
   ud_both_c: cover property (ud_cu_r && ud_cd_r);
   match_c: cover property (O_FAST_MATCH);
   err_per_c: cover property (cmd && cmd_status == udc_pkg::ST_BAD_PER);
endmodule : udc_top
`default_nettype wire

// ==== dv/udc_evt_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module udc_evt_src (
   // Clock and request from the bench
   input wire logic i_clk,
   input wire logic i_start,
   input wire logic [7:0] i_num,
   // Event pin and activity flag
   output logic o_evt,
   output logic o_busy
);
   // Half the shortest legal period: the pin never runs faster than the limit
   localparam int unsigned HALF = udc_pkg::FC_MIN_EVT_CYC / 2;
   initial begin
      o_evt = 1'b0;
      o_busy = 1'b0;
   end
   always begin
      @(posedge i_clk);
      if (i_start === 1'b1) begin
         o_busy <= 1'b1;
         repeat (i_num) begin
            repeat (HALF) @(posedge i_clk);
            o_evt <= 1'b1;
            repeat (HALF) @(posedge i_clk);
            o_evt <= 1'b0;
         end
         o_busy <= 1'b0;
      end
   end
endmodule : udc_evt_src
`default_nettype wire

// ==== dv/updown_counter_hsc_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module updown_counter_hsc_control_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, dir = 1'b0, go = 1'b0, serr;
   logic [7:0] addr = 8'h00, num = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, prdata;
   logic pready, pslverr, evt, ebusy, upq, dnq, udqu, udqd, match, fbusy, enable_out;
   int err_count = 0, checks_done = 0, mcnt = 0, p = 0, n, uc = 0, dc = 0, ud = 0, sg = 0;
   logic [1:0] ecfg [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
   logic [15:0] ecmd [5] = '{16'h0201, 16'h0101, 16'h0102, 16'h0104, 16'h0108};
   logic [15:0] ecode [5] = '{udc_pkg::ST_BAD_ID, udc_pkg::ST_BAD_DIR, udc_pkg::ST_BAD_CV,
                              udc_pkg::ST_BAD_RV, udc_pkg::ST_BAD_PER};
   always #20 clk = ~clk;
   always @(posedge clk) if (match === 1'b1) mcnt++;
   udc_top DUT (.I_REF_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wdat), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_FAST_EVT(evt), .I_FAST_DIR(dir), .O_UP_Q(upq), .O_DN_Q(dnq),
      .O_UD_QU(udqu), .O_UD_QD(udqd), .O_FAST_MATCH(match), .O_FAST_BUSY(fbusy),
      .O_ENABLE_OUT(enable_out));
   udc_evt_src SRC (.i_clk(clk), .i_start(go), .i_num(num), .o_evt(evt), .o_busy(ebusy));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Waits for pready with no assumed latency; the watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rdat, exp);
   endtask : rd
   task automatic pulse(input logic [7:0] b);
      apb(1'b1, udc_pkg::OFS_PC_CTRL, {23'h0, sg[0], b});
      apb(1'b1, udc_pkg::OFS_PC_CTRL, {23'h0, sg[0], 8'h00});
   endtask : pulse
   task automatic events(input logic [7:0] k);
      @(posedge clk);
      num <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (ebusy === 1'b1);
      repeat (6) @(posedge clk);
   endtask : events
   function automatic int sat(input int c, input int d, input int s);
      int r;
      r = c + d;
      if (s != 0) return (r > 32767) ? 32767 : ((r < -32768) ? -32768 : r);
      return (r > 65535) ? 65535 : ((r < 0) ? 0 : r);
   endfunction : sat
   function automatic logic [31:0] stat();
      return {28'h0, ud <= 0, ud >= p, dc <= 0, uc >= p};
   endfunction : stat
   task automatic counts();
      rd(udc_pkg::OFS_UP_CV, "up count", {16'h0, 16'(uc)});
      rd(udc_pkg::OFS_DN_CV, "down count", {16'h0, 16'(dc)});
      rd(udc_pkg::OFS_UD_CV, "updown count", {16'h0, 16'(ud)});
      rd(udc_pkg::OFS_PC_STAT, "limit flags", stat());
      chk("limit pins", {28'h0, udqd, udqu, dnq, upq}, stat());
   endtask : counts
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      stop_test();
   end
   initial begin
      void'($urandom(32'ha9b343a4));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      counts();
      rd(udc_pkg::OFS_FC_CMD, "command state", 32'h0001_0000);
      chk("busy pin", {31'h0, fbusy}, 32'h0);
      $display("reset test done");
      p = $urandom_range(2, 6);
      n = $urandom_range(1, 8);
      apb(1'b1, udc_pkg::OFS_PRESET, 32'(p));
      pulse(8'h88);
      dc = p;
      ud = p;
      // A level held over two evaluations must count once
      apb(1'b1, udc_pkg::OFS_PC_CTRL, 32'h05);
      pulse(8'h05);
      repeat (n - 1) pulse(8'h05);
      uc = n;
      dc = sat(p, -n, 0);
      counts();
      repeat (12) begin
         n = $urandom_range(0, 3);
         pulse({2'h0, n[1:0], 4'h0});
         ud = sat(ud, int'(n[0]) - int'(n[1]), 0);
         counts();
      end
      pulse(8'h02);
      uc = 0;
      counts();
      sg = 1;
      pulse(8'h40);
      ud = 0;
      repeat (2) pulse(8'h20);
      ud = sat(ud, -2, 1);
      counts();
      sg = 0;
      $display("program counter test done");
      apb(1'b1, udc_pkg::OFS_FC_NEW_DIR, 32'h1234);
      apb(1'b1, udc_pkg::OFS_FC_NEW_COUNT, 32'h5);
      apb(1'b1, udc_pkg::OFS_FC_NEW_REFERENCE, 32'h8);
      mcnt = 0;
      apb(1'b1, udc_pkg::OFS_FC_CMD, 32'h0106);
      rd(udc_pkg::OFS_FC_CMD, "command state", 32'h0001_0000);
      rd(udc_pkg::OFS_FC_COUNT, "fast count", 32'h5);
      rd(udc_pkg::OFS_FC_REF, "reference", 32'h8);
      events(8'h03);
      rd(udc_pkg::OFS_FC_COUNT, "fast count", 32'h8);
      chk("match pulses", 32'(mcnt), 32'h1);
      apb(1'b1, udc_pkg::OFS_FC_NEW_DIR, {16'h0, udc_pkg::DIR_BWD});
      apb(1'b1, udc_pkg::OFS_FC_CMD, 32'h0101);
      apb(1'b0, udc_pkg::OFS_FC_STATE, 32'h0);
      chk("forward flag", {31'h0, rdat[0]}, 32'h1);
      apb(1'b1, udc_pkg::OFS_FC_CFG, 32'h1);
      apb(1'b1, udc_pkg::OFS_FC_CMD, 32'h0101);
      apb(1'b0, udc_pkg::OFS_FC_STATE, 32'h0);
      chk("forward flag", {31'h0, rdat[0]}, 32'h0);
      events(8'h02);
      rd(udc_pkg::OFS_FC_COUNT, "fast count", 32'h6);
      apb(1'b1, udc_pkg::OFS_FC_CFG, 32'h0);
      dir <= 1'b1;
      events(8'h01);
      dir <= 1'b0;
      rd(udc_pkg::OFS_FC_COUNT, "fast count", 32'h5);
      apb(1'b1, udc_pkg::OFS_FC_CFG, 32'h2);
      apb(1'b1, udc_pkg::OFS_FC_NEW_PER, {16'h0, udc_pkg::PER_100MS});
      apb(1'b1, udc_pkg::OFS_FC_CMD, 32'h0108);
      apb(1'b0, udc_pkg::OFS_FC_STATE, 32'h0);
      chk("period", {16'h0, rdat[31:16]}, {16'h0, udc_pkg::PER_100MS});
      $display("fast counter test done");
      apb(1'b1, udc_pkg::OFS_FC_NEW_DIR, 32'h2);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, udc_pkg::OFS_FC_CFG, {30'h0, ecfg[i]});
         apb(1'b1, udc_pkg::OFS_FC_CMD, {16'h0, ecmd[i]});
         rd(udc_pkg::OFS_FC_CMD, "error code", {16'h0, ecode[i]});
         chk("enable out", {31'h0, enable_out}, 32'h0);
         rd(udc_pkg::OFS_FC_COUNT, "fast count", 32'h5);
      end
      apb(1'b1, udc_pkg::OFS_FC_CMD, 32'h0100);
      chk("enable out", {31'h0, enable_out}, 32'h1);
      apb(1'b1, udc_pkg::OFS_UP_CV, 32'h7);
      rd(udc_pkg::OFS_UP_CV, "read only", 32'h0);
      rd(8'h3c, "unmapped data", 32'h0);
      chk("unmapped error", {31'h0, serr}, 32'h1);
      $display("error test done");
      stop_test();
   end
endmodule : updown_counter_hsc_control_tb
`default_nettype wire
